// [hdl/smooth_pole.sv]
`timescale 1ns/10ps
module smooth_pole (
  // Clocking
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  // Control
  input wire logic tick,
  input wire logic flush,
  input wire logic [3:0] tau,
  // Stream
  input wire logic signed [15:0] inDelta,
  output logic signed [15:0] outDelta,
  output logic idle
);
  logic signed [15:0] pendQ;
  logic signed [15:0] pendIn;
  logic signed [15:0] scaled;
  logic signed [15:0] moved;
  logic signed [32:0] prod;
  logic [31:0] den;
  logic [16:0] gain;

  // ----------------------------------------
  // One pole on position: each sample releases a fixed share of what is pending
  // ----------------------------------------
  assign den = (tau == 4'h0) ? 32'h1 : step_axis_pkg::TAU_PER_UNIT * 32'(tau);
  assign gain = 17'(step_axis_pkg::GAIN_NUM / den);
  assign pendIn = pendQ + inDelta;
  assign prod = pendIn * $signed(gain);
  assign scaled = 16'(prod >>> step_axis_pkg::FRAC);
  // Truncation alone would strand a remainder forever, so at least one step leaves
  assign moved = (tau == 4'h0) ? pendIn :
                 (scaled == 16'sh0000 && pendIn != 16'sh0000) ?
                 ((pendIn < 0) ? 16'shFFFF : 16'sh0001) : scaled;
  assign idle = (pendQ == 16'sh0000);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pendQ <= 16'sh0000;
      outDelta <= 16'sh0000;
    end else if (ce) begin
      if (flush) begin
        pendQ <= 16'sh0000;
        outDelta <= 16'sh0000;
      end else if (tick) begin
        pendQ <= pendIn - moved;
        outDelta <= moved;
      end else begin
        outDelta <= 16'sh0000;
      end
    end
  end

endmodule

// [hdl/step_axis_pkg.sv]
package step_axis_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_NS = 5;
  localparam int unsigned SAMPLE_NS = 1000;
  localparam int unsigned SAMPLE_CYC = SAMPLE_NS / CLK_NS;
  localparam int unsigned STEP_HI_NS = 50;
  localparam int unsigned STEP_HI_CYC = (STEP_HI_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STEP_LO_NS = 50;
  localparam int unsigned STEP_LO_CYC = (STEP_LO_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_MTYPE = 8'h00;
  localparam logic [7:0] OFF_STEP_SMOOTH = 8'h04;
  localparam logic [7:0] OFF_PROF_SMOOTH = 8'h08;
  localparam logic [7:0] OFF_REFPOS = 8'h0C;
  localparam logic [7:0] OFF_STEPCNT = 8'h10;
  localparam logic [7:0] OFF_ENCPOS = 8'h14;
  localparam logic [7:0] OFF_AUXPOS = 8'h18;
  localparam logic [7:0] OFF_DEFPOS = 8'h1C;
  localparam logic [7:0] OFF_DEFENC = 8'h20;
  localparam logic [7:0] OFF_TARGET = 8'h24;
  localparam logic [7:0] OFF_WAIT = 8'h28;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int TYPE_HIGH_BIT = 0;
  localparam int TYPE_REV_BIT = 1;
  localparam int TYPE_STEPPER_BIT = 2;
  localparam logic [2:0] TYPE_RESET = 3'h4;
  localparam logic [3:0] STEP_SMOOTH_RESET = 4'h2;
  localparam logic [3:0] PROF_SMOOTH_RESET = 4'h0;
  localparam int WAIT_PROFILE_BIT = 0;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_PROFILE_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_EMPTY_BIT = 3;

  // ----------------------------------------
  // Filter scaling
  // ----------------------------------------
  localparam int unsigned TAU_PER_UNIT = 3;
  localparam int unsigned GAIN_NUM = 65536;
  localparam int FRAC = 16;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic step;
    logic dir;
    logic busy;
  } prof_t;

  typedef struct packed {
    logic step;
    logic dir;
  } drive_t;

  localparam drive_t DRIVE_RESET = '{step: 1'b1, dir: 1'b0};

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HIGH = 3'b010,
    ST_LOW = 3'b100
  } pulse_st_t;

endpackage

// [hdl/stepper_pulse_output_axis.sv]
`timescale 1ns/10ps
// How it works
// - Type 2 gives active-low step pulses, type -2 active-high, direction normal.
// - Types 2.5 and -2.5 keep that polarity but invert the direction output.
// - Profiler pulses pass a single-pole smoothing filter that evens step spacing.
// - Steps lag the profiler more as the step smoothing constant grows.
// - Step smoothing resets to 2, six samples; never zero in stepper mode.
// - Reference position counts every profiler pulse and is readable.
// - Filtered pulses wait in a buffer before reaching the driver.
// - Step count tracks pulses actually emitted and is readable.
// - Define position loads one value into reference position and step count.
// - Motion complete wait stalls until step count equals the commanded target.
// - After motion wait releases when the profiler finishes, steps may pend.
// - In stepper mode the auxiliary encoder pins are ignored.
// - Main encoder position is readable and loadable by define encoder.
// - No servo loop: encoder data never touches the step output.
// - Profile smoothing constant filters the profile ahead of step smoothing.
// - Each emitted step also counts in the auxiliary encoder register.
module stepper_pulse_output_axis (
  // Clock, reset, freeze
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Motion profiler
  input wire step_axis_pkg::prof_t prof,
  // Encoder pins
  input wire logic encA,
  input wire logic encB,
  input wire logic auxA,
  input wire logic auxB,
  // Step driver and command sequencer
  output step_axis_pkg::drive_t drive,
  output logic cmdStall
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] tickCntQ;
  logic tickDlyQ;
  logic tick;
  logic [2:0] mtypeQ;
  logic [3:0] stepSmoothQ;
  logic [3:0] profSmoothQ;
  logic [3:0] stepTau;
  logic stepperEn;
  logic activeHigh;
  logic dirRev;
  logic setup;
  logic wrEn;
  logic mapped;
  logic [31:0] rdMux;
  logic [31:0] statusW;
  logic wrMtype;
  logic wrStepSmooth;
  logic wrProfSmooth;
  logic wrDefPos;
  logic wrDefEnc;
  logic wrTarget;
  logic wrWait;
  logic signed [15:0] stepIn;
  logic signed [15:0] profAccQ;
  logic signed [15:0] accSum;
  logic signed [31:0] refPosQ;
  logic signed [15:0] profOut;
  logic signed [15:0] stepOut;
  logic profIdle;
  logic stepIdle;
  logic signed [15:0] bufQ;
  logic signed [15:0] drain;
  logic pulseStart;
  step_axis_pkg::pulse_st_t stQ;
  step_axis_pkg::pulse_st_t stD;
  logic [7:0] cntQ;
  logic [7:0] cntD;
  logic dirQ;
  logic dirD;
  logic signed [31:0] stepCountQ;
  logic signed [31:0] auxPosQ;
  logic signed [31:0] encPosQ;
  logic signed [31:0] targetQ;
  logic doneArmQ;
  logic profArmQ;
  logic bufEmpty;
  logic [1:0] encS1;
  logic [1:0] encS2;
  logic [1:0] encPrevQ;
  logic [1:0] auxS1;
  logic [1:0] auxS2;
  logic [1:0] auxPrevQ;
  logic signed [1:0] encDelta;
  logic signed [1:0] auxDelta;

  // Quadrature order is 00, 01, 11, 10 forward; a double jump is dropped
  function automatic logic signed [1:0] quadMove(input logic [1:0] prev,
                                                 input logic [1:0] cur);
    logic fwd;
    logic rev;
    fwd = (cur == {prev[0], ~prev[1]});
    rev = (cur == {~prev[0], prev[1]});
    quadMove = fwd ? 2'sh1 : (rev ? 2'sh3 : 2'sh0);
  endfunction

  // ----------------------------------------
  // Sample tick
  // ----------------------------------------
  assign tick = (tickCntQ == 8'(step_axis_pkg::SAMPLE_CYC - 1));

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tickCntQ <= 8'h00;
      tickDlyQ <= 1'b0;
    end else if (ce) begin
      tickCntQ <= tick ? 8'h00 : tickCntQ + 8'h01;
      tickDlyQ <= tick;
    end
  end

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign setup = psel & ~penable;
  assign wrEn = psel & penable & pwrite & ce;
  assign pready = ce;
  assign wrMtype = wrEn & (paddr == step_axis_pkg::OFF_MTYPE);
  assign wrStepSmooth = wrEn & (paddr == step_axis_pkg::OFF_STEP_SMOOTH);
  assign wrProfSmooth = wrEn & (paddr == step_axis_pkg::OFF_PROF_SMOOTH);
  assign wrDefPos = wrEn & (paddr == step_axis_pkg::OFF_DEFPOS);
  assign wrDefEnc = wrEn & (paddr == step_axis_pkg::OFF_DEFENC);
  assign wrTarget = wrEn & (paddr == step_axis_pkg::OFF_TARGET);
  assign wrWait = wrEn & (paddr == step_axis_pkg::OFF_WAIT);
  assign mapped = (paddr <= step_axis_pkg::OFF_WAIT) && (paddr[1:0] == 2'h0);

  always_comb begin
    statusW = 32'h0;
    statusW[step_axis_pkg::STAT_DONE_BIT] = doneArmQ;
    statusW[step_axis_pkg::STAT_PROFILE_BIT] = profArmQ;
    statusW[step_axis_pkg::ST_BUSY_BIT] = prof.busy;
    statusW[step_axis_pkg::ST_EMPTY_BIT] = bufEmpty;
  end

  // Define position and define encoder read back as zero
  assign rdMux =
    (paddr == step_axis_pkg::OFF_MTYPE) ? {29'h0, mtypeQ} :
    (paddr == step_axis_pkg::OFF_STEP_SMOOTH) ? {28'h0, stepSmoothQ} :
    (paddr == step_axis_pkg::OFF_PROF_SMOOTH) ? {28'h0, profSmoothQ} :
    (paddr == step_axis_pkg::OFF_REFPOS) ? refPosQ :
    (paddr == step_axis_pkg::OFF_STEPCNT) ? stepCountQ :
    (paddr == step_axis_pkg::OFF_ENCPOS) ? encPosQ :
    (paddr == step_axis_pkg::OFF_AUXPOS) ? auxPosQ :
    (paddr == step_axis_pkg::OFF_TARGET) ? targetQ :
    (paddr == step_axis_pkg::OFF_WAIT) ? statusW : 32'h0;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (ce && setup) begin
      prdata <= pwrite ? 32'h0 : rdMux;
      pslverr <= ~mapped;
    end
  end

  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  assign stepperEn = mtypeQ[step_axis_pkg::TYPE_STEPPER_BIT];
  assign activeHigh = mtypeQ[step_axis_pkg::TYPE_HIGH_BIT];
  assign dirRev = mtypeQ[step_axis_pkg::TYPE_REV_BIT];
  assign stepTau = (stepSmoothQ == 4'h0) ? 4'h1 : stepSmoothQ;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mtypeQ <= step_axis_pkg::TYPE_RESET;
      stepSmoothQ <= step_axis_pkg::STEP_SMOOTH_RESET;
      profSmoothQ <= step_axis_pkg::PROF_SMOOTH_RESET;
    end else if (ce) begin
      if (wrMtype) mtypeQ <= pwdata[2:0];
      if (wrStepSmooth) stepSmoothQ <= pwdata[3:0];
      if (wrProfSmooth) profSmoothQ <= pwdata[3:0];
    end
  end

  // ----------------------------------------
  // Profiler input and reference position
  // ----------------------------------------
  assign stepIn = prof.step ? (prof.dir ? 16'shFFFF : 16'sh0001) : 16'sh0000;
  assign accSum = profAccQ + stepIn;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      profAccQ <= 16'sh0000;
      refPosQ <= 32'sh0;
    end else if (ce) begin
      profAccQ <= (tick || wrDefPos) ? 16'sh0000 : accSum;
      refPosQ <= wrDefPos ? pwdata : refPosQ + 32'(stepIn);
    end
  end

  // ----------------------------------------
  // Profile smoothing, then step smoothing one cycle later
  // ----------------------------------------
  smooth_pole profFilt (
    .clock(clock),
    .rst_b(rst_b),
    .ce(ce),
    .tick(tick),
    .flush(wrDefPos),
    .tau(profSmoothQ),
    .inDelta(accSum),
    .outDelta(profOut),
    .idle(profIdle)
  );

  smooth_pole stepFilt (
    .clock(clock),
    .rst_b(rst_b),
    .ce(ce),
    .tick(tickDlyQ),
    .flush(wrDefPos),
    .tau(stepTau),
    .inDelta(profOut),
    .outDelta(stepOut),
    .idle(stepIdle)
  );

  // ----------------------------------------
  // Pending step buffer
  // ----------------------------------------
  // Steps leave the buffer one at a time, no faster than the pulse rate, however many one sample adds
  assign pulseStart = (stQ == step_axis_pkg::ST_IDLE) && stepperEn && (bufQ != 16'sh0000);
  assign drain = pulseStart ? ((bufQ < 0) ? 16'shFFFF : 16'sh0001) : 16'sh0000;
  assign bufEmpty = (bufQ == 16'sh0000) && stepIdle && profIdle &&
                    (stQ == step_axis_pkg::ST_IDLE);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bufQ <= 16'sh0000;
    end else if (ce) begin
      bufQ <= wrDefPos ? 16'sh0000 : bufQ + stepOut - drain;
    end
  end

  // ----------------------------------------
  // Step pulse generator
  // ----------------------------------------
  always_comb begin
    case (stQ)
      step_axis_pkg::ST_IDLE: stD = pulseStart ? step_axis_pkg::ST_HIGH : step_axis_pkg::ST_IDLE;
      step_axis_pkg::ST_HIGH: stD = (cntQ == 8'h00) ? step_axis_pkg::ST_LOW : step_axis_pkg::ST_HIGH;
      step_axis_pkg::ST_LOW: stD = (cntQ == 8'h00) ? step_axis_pkg::ST_IDLE : step_axis_pkg::ST_LOW;
      default: stD = step_axis_pkg::ST_IDLE;
    endcase
  end

  assign cntD = pulseStart ? 8'(step_axis_pkg::STEP_HI_CYC - 1) :
                (stQ == step_axis_pkg::ST_HIGH && cntQ == 8'h00) ?
                8'(step_axis_pkg::STEP_LO_CYC - 1) :
                (cntQ != 8'h00) ? cntQ - 8'h01 : 8'h00;
  assign dirD = pulseStart ? (bufQ < 0) : dirQ;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stQ <= step_axis_pkg::ST_IDLE;
      cntQ <= 8'h00;
      dirQ <= 1'b0;
      drive <= step_axis_pkg::DRIVE_RESET;
    end else if (ce) begin
      stQ <= stD;
      cntQ <= cntD;
      dirQ <= dirD;
      drive.step <= (stD == step_axis_pkg::ST_HIGH) ^ ~activeHigh;
      drive.dir <= dirD ^ dirRev;
    end
  end

  // ----------------------------------------
  // Step count and auxiliary register
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stepCountQ <= 32'sh0;
      auxPosQ <= 32'sh0;
    end else if (ce) begin
      stepCountQ <= wrDefPos ? pwdata : stepCountQ + 32'(drain);
      // Aux pins are dead in stepper mode; emitted steps count instead
      auxPosQ <= stepperEn ? auxPosQ + 32'(drain) : auxPosQ + 32'(auxDelta);
    end
  end

  // ----------------------------------------
  // Encoders: pins pass two flops first
  // ----------------------------------------
  assign encDelta = quadMove(encPrevQ, encS2);
  assign auxDelta = quadMove(auxPrevQ, auxS2);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      encS1 <= 2'h0;
      encS2 <= 2'h0;
      encPrevQ <= 2'h0;
      auxS1 <= 2'h0;
      auxS2 <= 2'h0;
      auxPrevQ <= 2'h0;
      encPosQ <= 32'sh0;
    end else if (ce) begin
      encS1 <= {encA, encB};
      encS2 <= encS1;
      encPrevQ <= encS2;
      auxS1 <= {auxA, auxB};
      auxS2 <= auxS1;
      auxPrevQ <= auxS2;
      // Monitoring only; nothing here reaches the step path
      encPosQ <= wrDefEnc ? pwdata : encPosQ + 32'(encDelta);
    end
  end

  // ----------------------------------------
  // Wait conditions
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      targetQ <= 32'sh0;
      doneArmQ <= 1'b0;
      profArmQ <= 1'b0;
    end else if (ce) begin
      if (wrTarget) targetQ <= pwdata;
      // Arming wins over a release in the same cycle
      if (wrTarget) doneArmQ <= 1'b1;
      else if (stepCountQ == targetQ) doneArmQ <= 1'b0;
      if (wrWait && pwdata[step_axis_pkg::WAIT_PROFILE_BIT]) profArmQ <= 1'b1;
      else if (!prof.busy) profArmQ <= 1'b0;
    end
  end

  assign cmdStall = doneArmQ | profArmQ;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b || !ce);

  a_step_low_pol: assert property (
    $stable(mtypeQ) && !activeHigh |-> drive.step == (stQ != step_axis_pkg::ST_HIGH))
    else $error("active-low step level wrong");
  a_step_high_pol: assert property (
    $stable(mtypeQ) && activeHigh |-> drive.step == (stQ == step_axis_pkg::ST_HIGH))
    else $error("active-high step level wrong");
  a_dir_reverse: assert property (
    $stable(mtypeQ) && stQ == step_axis_pkg::ST_HIGH |-> drive.dir == (dirQ ^ dirRev))
    else $error("direction sense wrong");
  a_pulse_width: assert property (
    pulseStart |=> (stQ == step_axis_pkg::ST_HIGH) [*8])
    else $error("step pulse too short");
  a_count_step: assert property (
    pulseStart && bufQ > 0 && !wrDefPos |=> stepCountQ == $past(stepCountQ) + 1)
    else $error("step count missed a step");
  a_ref_count: assert property (
    prof.step && !prof.dir && !wrDefPos |=> refPosQ == $past(refPosQ) + 1)
    else $error("reference position missed a pulse");
  a_def_pos: assert property (
    wrDefPos |=> refPosQ == stepCountQ && bufQ == 16'sh0000)
    else $error("define position mismatch");
  a_mc_hold: assert property (
    doneArmQ && stepCountQ != targetQ |=> cmdStall)
    else $error("motion complete released early");
  a_am_release: assert property (
    profArmQ && !prof.busy && !wrWait |=> !profArmQ)
    else $error("after motion wait not released");
  a_aux_feed: assert property (
    stepperEn && pulseStart && bufQ < 0 |=> auxPosQ == $past(auxPosQ) - 1)
    else $error("aux register missed a step");
  a_tick_gap: assert property (
    tick |=> !tick [*8])
    else $error("sample ticks too close");
  a_smooth_floor: assert property (
    stepSmoothQ == 4'h0 |-> stepTau == 4'h1)
    else $error("step smoothing fell to zero");

  c_step_rev: cover property (pulseStart && bufQ < 0);
  c_done_wait: cover property ($fell(doneArmQ));
  c_prof_wait: cover property ($fell(profArmQ) && !bufEmpty);
  c_def_pos: cover property (wrDefPos);

endmodule

// [testbench/stepper_driver_model.sv]
`timescale 1ns/10ps
module stepper_driver_model (
  // Clocking
  input wire logic clock,
  input wire logic rst_b,
  // Step and direction from the axis
  input wire step_axis_pkg::drive_t drive,
  input wire logic activeHigh,
  // Feedback encoder and motor shaft
  output logic encA,
  output logic encB,
  output logic signed [31:0] motorPos
);
  // ----------------------------------------
  // Step edge detection
  // ----------------------------------------
  // Only the active edge moves the shaft, so an idle level change on a
  // polarity switch is never mistaken for a step
  logic prevStep;
  wire logic activeEdge = activeHigh ? (drive.step & ~prevStep) : (~drive.step & prevStep);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prevStep <= 1'b1;
      motorPos <= '0;
    end else begin
      prevStep <= drive.step;
      if (activeEdge) begin
        motorPos <= drive.dir ? motorPos - 32'sd1 : motorPos + 32'sd1;
      end
    end
  end

  // ----------------------------------------
  // Feedback encoder
  // ----------------------------------------
  // Quadrature follows the shaft and is wired to the main input only
  assign encA = motorPos[1];
  assign encB = motorPos[1] ^ motorPos[0];
endmodule

// [testbench/tb.sv]
`timescale 1ns/10ps
module tb;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cmdStall;
  logic encA;
  logic encB;
  logic auxA = 1'b0;
  logic auxB = 1'b0;
  logic activeHigh = 1'b0;
  step_axis_pkg::prof_t prof = '0;
  step_axis_pkg::drive_t drive;
  logic signed [31:0] motorPos;
  logic [31:0] dat;
  logic [31:0] a0;
  logic [31:0] m0;
  logic [31:0] e5;
  logic er;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t[3];
  int k;

  stepper_pulse_output_axis stepper_pulse_output_axis_i (.clock(clock), .rst_b(rst_b),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .prof(prof),
    .encA(encA), .encB(encB), .auxA(auxA), .auxB(auxB), .drive(drive), .cmdStall(cmdStall));

  stepper_driver_model stepper_driver_model_i (.clock(clock), .rst_b(rst_b), .drive(drive),
    .activeHigh(activeHigh), .encA(encA), .encB(encB), .motorPos(motorPos));

  initial begin
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) cyc <= cyc + 1;

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Entered just after a rising edge; leaves one idle edge so psel is never
  // assigned twice in one time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 100);
    dat = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic pulses(input int n, input logic dn);
    repeat (n) begin
      prof.step <= 1'b1;
      prof.dir <= dn;
      @(posedge clock);
      prof.step <= 1'b0;
      @(posedge clock);
    end
  endtask

  task automatic drain(input logic [31:0] e);
    int n;
    n = 0;
    do begin
      rd(step_axis_pkg::OFF_STEPCNT);
      n++;
    end while (dat !== e && n < 3000);
  endtask

  task automatic tally_and_finish();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #400000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rd(step_axis_pkg::OFF_MTYPE);
    chk(dat, 32'h4, "mtype reset");
    rd(step_axis_pkg::OFF_STEP_SMOOTH);
    chk(dat, 32'h2, "step smooth reset");
    rd(step_axis_pkg::OFF_PROF_SMOOTH);
    chk(dat, 32'h0, "profile smooth reset");
    chk({30'h0, drive}, 32'h2, "drive idle");
    rd(8'h2C);
    chk({31'h0, er}, 32'h1, "unmapped err");
    $display("test reset done");

    // Every motor type: polarity, direction, counters and feedback
    for (int i = 0; i < 4; i++) begin
      activeHigh <= i[0];
      wr(step_axis_pkg::OFF_MTYPE, 32'h4 + i);
      wr(step_axis_pkg::OFF_DEFPOS, 32'h40);
      wr(step_axis_pkg::OFF_DEFENC, 32'h0);
      rd(step_axis_pkg::OFF_AUXPOS);
      a0 = dat;
      m0 = motorPos;
      e5 = i[1] ? 32'hFFFF_FFFB : 32'h5;
      pulses(5, 1'b0);
      rd(step_axis_pkg::OFF_REFPOS);
      chk(dat, 32'h45, "refpos");
      drain(32'h45);
      chk(dat, 32'h45, "stepcnt");
      repeat (10) @(posedge clock);
      chk({31'h0, drive.step}, {31'h0, ~i[0]}, "idle level");
      chk(motorPos - m0, e5, "motor moves");
      rd(step_axis_pkg::OFF_ENCPOS);
      chk(dat, e5, "encpos");
      rd(step_axis_pkg::OFF_AUXPOS);
      chk(dat - a0, 32'h5, "auxpos");
    end
    activeHigh <= 1'b0;
    wr(step_axis_pkg::OFF_MTYPE, 32'h4);
    $display("test motor types done");

    // Lag grows with either smoothing constant
    for (int i = 0; i < 3; i++) begin
      wr(step_axis_pkg::OFF_STEP_SMOOTH, i == 1 ? 32'h8 : 32'h1);
      wr(step_axis_pkg::OFF_PROF_SMOOTH, i == 2 ? 32'h4 : 32'h0);
      wr(step_axis_pkg::OFF_DEFPOS, 32'h0);
      pulses(20, 1'b0);
      t[i] = cyc;
      drain(32'd20);
      t[i] = cyc - t[i];
      chk(dat, 32'd20, "smoothed count");
    end
    chk({31'h0, t[1] > t[0]}, 32'h1, "step smooth lag");
    chk({31'h0, t[2] > t[0]}, 32'h1, "profile smooth lag");
    wr(step_axis_pkg::OFF_PROF_SMOOTH, 32'h0);
    $display("test smoothing done");

    wr(step_axis_pkg::OFF_STEP_SMOOTH, 32'h8);
    wr(step_axis_pkg::OFF_DEFPOS, 32'h0);
    wr(step_axis_pkg::OFF_TARGET, 32'd10);
    pulses(10, 1'b0);
    chk({31'h0, cmdStall}, 32'h1, "complete stall");
    k = 0;
    while (cmdStall !== 1'b0 && k < 8000) begin
      @(posedge clock);
      k++;
    end
    rd(step_axis_pkg::OFF_STEPCNT);
    chk(dat, 32'd10, "complete release");
    $display("test motion complete done");

    wr(step_axis_pkg::OFF_DEFPOS, 32'h0);
    prof.busy <= 1'b1;
    wr(step_axis_pkg::OFF_WAIT, 32'h1);
    chk({31'h0, cmdStall}, 32'h1, "profile wait stall");
    pulses(10, 1'b0);
    prof.busy <= 1'b0;
    repeat (5) @(posedge clock);
    chk({31'h0, cmdStall}, 32'h0, "profile wait release");
    rd(step_axis_pkg::OFF_STEPCNT);
    chk({31'h0, dat != 32'd10}, 32'h1, "steps pend");
    drain(32'd10);
    $display("test after motion done");

    // Stepper output off: steps wait in the buffer until it returns
    wr(step_axis_pkg::OFF_MTYPE, 32'h0);
    wr(step_axis_pkg::OFF_DEFPOS, 32'h0);
    pulses(3, 1'b1);
    repeat (1200) @(posedge clock);
    rd(step_axis_pkg::OFF_STEPCNT);
    chk(dat, 32'h0, "held");
    wr(step_axis_pkg::OFF_MTYPE, 32'h4);
    drain(32'hFFFF_FFFD);
    chk(dat, 32'hFFFF_FFFD, "released");
    rd(step_axis_pkg::OFF_AUXPOS);
    a0 = dat;
    for (int j = 1; j < 9; j++) begin
      auxA <= j[1];
      auxB <= j[1] ^ j[0];
      repeat (4) @(posedge clock);
    end
    rd(step_axis_pkg::OFF_AUXPOS);
    chk(dat, a0, "aux pins ignored");
    $display("test buffer and aux done");

    // Clock enable low: profiler pulses must not reach the counter
    ce <= 1'b0;
    pulses(3, 1'b0);
    ce <= 1'b1;
    rd(step_axis_pkg::OFF_REFPOS);
    chk(dat, 32'hFFFF_FFFD, "frozen refpos");
    $display("test freeze done");
    tally_and_finish();
  end
endmodule
